// file: design/oie_consts.svh
`ifndef OIE_CONSTS_SVH
`define OIE_CONSTS_SVH
// opcode fields, bits 13:8 of the program word, bits 13:10 for the literal load
`define OIE_OP_INC_SKIP 6'h0F
`define OIE_OP_OR_FILE 6'h04
`define OIE_OP_OR_LIT 6'h38
`define OIE_OP_LOAD_LIT_HI 4'hC
// field positions
`define OIE_OPC_HI 13
`define OIE_OPC_LO 8
`define OIE_DEST_BIT 7
`define OIE_FADDR_HI 6
`define OIE_LIT_HI 7
// reset values
`define OIE_W_RST 8'h00
`define OIE_PC_RST 13'h0000
// quarter phases per instruction cycle
`define OIE_QUARTERS 4
`endif

// file: design/oie_pkg.sv
package oie_pkg;
   typedef enum logic [1:0] {
      OIE_Q1 = 2'b00,
      OIE_Q2 = 2'b01,
      OIE_Q3 = 2'b11,
      OIE_Q4 = 2'b10
   } oie_phase_t;

   typedef enum logic [2:0] {
      OIE_K_NONE = 3'h0,
      OIE_K_INC_SKIP = 3'h1,
      OIE_K_OR_FILE = 3'h2,
      OIE_K_OR_LIT = 3'h3,
      OIE_K_LOAD_LIT = 3'h4
   } oie_kind_t;

   typedef struct packed {
      oie_kind_t kind;
      logic to_file;
      logic [6:0] faddr;
      logic [7:0] lit;
   } oie_dec_t;

   typedef struct packed {
      logic we;
      logic [6:0] addr;
      logic [7:0] data;
   } oie_fwr_t;
endpackage

// file: design/oie_decoder.sv
`timescale 1ns/1ps
`include "oie_consts.svh"
module oie_decoder (
   // program word
   input wire logic [13:0] instr,
   // decoded fields
   output oie_pkg::oie_dec_t dec
);
   always_comb begin
      dec.faddr = instr[`OIE_FADDR_HI:0];
      dec.lit = instr[`OIE_LIT_HI:0];
      dec.to_file = instr[`OIE_DEST_BIT];
      dec.kind = oie_pkg::OIE_K_NONE;
      if (instr[`OIE_OPC_HI:`OIE_OPC_LO] == `OIE_OP_INC_SKIP) begin
         dec.kind = oie_pkg::OIE_K_INC_SKIP;
      end else if (instr[`OIE_OPC_HI:`OIE_OPC_LO] == `OIE_OP_OR_FILE) begin
         dec.kind = oie_pkg::OIE_K_OR_FILE;
      end else if (instr[`OIE_OPC_HI:`OIE_OPC_LO] == `OIE_OP_OR_LIT) begin
         dec.kind = oie_pkg::OIE_K_OR_LIT;
      end else if (instr[`OIE_OPC_HI:`OIE_OPC_HI-3] == `OIE_OP_LOAD_LIT_HI)
      begin
         dec.kind = oie_pkg::OIE_K_LOAD_LIT;
      end
   end
endmodule // oie_decoder

// file: design/oie_exec.sv
`timescale 1ns/1ps
`include "oie_consts.svh"
module oie_exec (
   // clock and control
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // program word fetch
   input wire logic [13:0] instr,
   output logic [12:0] pc,
   // register file
   output logic [6:0] file_raddr,
   input wire logic [7:0] file_rdata,
   output oie_pkg::oie_fwr_t file_wr,
   // core state
   output logic [7:0] w_acc,
   output logic zero_flag,
   output oie_pkg::oie_phase_t phase,
   output logic skipping
);
   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   oie_pkg::oie_phase_t ph_q;
   oie_pkg::oie_phase_t ph_d;
   oie_pkg::oie_dec_t dec_raw;
   oie_pkg::oie_dec_t dec_q;
   oie_pkg::oie_dec_t dec_d;
   logic [7:0] opnd_q;
   logic [7:0] opnd_d;
   logic [7:0] res_q;
   logic [7:0] res_d;
   logic [7:0] w_q;
   logic [7:0] w_d;
   logic z_q;
   logic z_d;
   logic skip_q;
   logic skip_d;
   logic [12:0] pc_q;
   logic [12:0] pc_d;
   oie_pkg::oie_fwr_t fw_q;
   oie_pkg::oie_fwr_t fw_d;

   oie_decoder u_dec (
      .instr(instr),
      .dec(dec_raw)
   );

   ////////////////////////////////////////////////////////////////////////
   // quarter sequencer and datapath
   always_comb begin
      ph_d = ph_q;
      dec_d = dec_q;
      opnd_d = opnd_q;
      res_d = res_q;
      w_d = w_q;
      z_d = z_q;
      skip_d = skip_q;
      pc_d = pc_q;
      fw_d = fw_q;
      fw_d.we = 1'b0;
      unique case (ph_q)
         oie_pkg::OIE_Q1: begin
            ph_d = oie_pkg::OIE_Q2;
            dec_d = dec_raw;
            if (skip_q) begin
               dec_d.kind = oie_pkg::OIE_K_NONE;
            end
         end
         oie_pkg::OIE_Q2: begin
            ph_d = oie_pkg::OIE_Q3;
            // literal kinds bypass the file read
            opnd_d = file_rdata;
            if (dec_q.kind == oie_pkg::OIE_K_OR_LIT ||
                dec_q.kind == oie_pkg::OIE_K_LOAD_LIT) begin
               opnd_d = dec_q.lit;
            end
         end
         oie_pkg::OIE_Q3: begin
            ph_d = oie_pkg::OIE_Q4;
            unique case (dec_q.kind)
               oie_pkg::OIE_K_INC_SKIP: res_d = opnd_q + 8'h01;
               oie_pkg::OIE_K_OR_FILE,
               oie_pkg::OIE_K_OR_LIT: res_d = w_q | opnd_q;
               oie_pkg::OIE_K_LOAD_LIT: res_d = opnd_q;
               default: res_d = opnd_q;
            endcase
         end
         oie_pkg::OIE_Q4: begin
            ph_d = oie_pkg::OIE_Q1;
            // a skipped word still steps pc, so a skip totals two
            pc_d = pc_q + 13'h0001;
            skip_d = 1'b0;
            fw_d.addr = dec_q.faddr;
            fw_d.data = res_q;
            unique case (dec_q.kind)
               oie_pkg::OIE_K_INC_SKIP: begin
                  if (dec_q.to_file) begin
                     fw_d.we = 1'b1;
                  end else begin
                     w_d = res_q;
                  end
                  skip_d = is_zero(res_q);
               end
               oie_pkg::OIE_K_OR_FILE: begin
                  if (dec_q.to_file) begin
                     fw_d.we = 1'b1;
                  end else begin
                     w_d = res_q;
                  end
                  z_d = is_zero(res_q);
               end
               oie_pkg::OIE_K_OR_LIT: begin
                  w_d = res_q;
                  z_d = is_zero(res_q);
               end
               oie_pkg::OIE_K_LOAD_LIT: w_d = res_q;
               default: begin
               end
            endcase
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ph_q <= oie_pkg::OIE_Q1;
         dec_q <= '0;
         opnd_q <= 8'h00;
         res_q <= 8'h00;
         w_q <= `OIE_W_RST;
         z_q <= 1'b0;
         skip_q <= 1'b0;
         pc_q <= `OIE_PC_RST;
         fw_q <= '0;
      end else if (clk_en) begin
         ph_q <= ph_d;
         dec_q <= dec_d;
         opnd_q <= opnd_d;
         res_q <= res_d;
         w_q <= w_d;
         z_q <= z_d;
         skip_q <= skip_d;
         pc_q <= pc_d;
         fw_q <= fw_d;
      end
   end

   assign pc = pc_q;
   assign file_raddr = dec_q.faddr;
   assign file_wr = fw_q;
   assign w_acc = w_q;
   assign zero_flag = z_q;
   assign phase = ph_q;
   assign skipping = skip_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   phase_order_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q4
      |=> ph_q == oie_pkg::OIE_Q1) else $error("phase order broken");
   inc_result_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q3 &&
      dec_q.kind == oie_pkg::OIE_K_INC_SKIP
      |=> res_q == $past(opnd_q) + 8'h01) else $error("increment wrong");
   inc_flag_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q4 &&
      dec_q.kind == oie_pkg::OIE_K_INC_SKIP |=> $stable(z_q))
      else $error("increment touched zero flag");
   skip_set_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q4 &&
      dec_q.kind == oie_pkg::OIE_K_INC_SKIP && res_q == 8'h00
      |=> skip_q) else $error("skip not armed");
   skip_nop_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q1 &&
      skip_q |=> dec_q.kind == oie_pkg::OIE_K_NONE)
      else $error("skipped word executed");
   pc_step_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q4
      |=> pc_q == $past(pc_q) + 13'h0001) else $error("pc step wrong");
   or_zero_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q4 &&
      dec_q.kind == oie_pkg::OIE_K_OR_LIT |=> z_q == (w_q == 8'h00))
      else $error("zero flag wrong");
   file_dest_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q4 &&
      dec_q.kind == oie_pkg::OIE_K_OR_FILE && dec_q.to_file
      |=> fw_q.we && $stable(w_q)) else $error("or to file wrong");
   load_lit_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q4 &&
      dec_q.kind == oie_pkg::OIE_K_LOAD_LIT
      |=> w_q == $past(dec_q.lit) && $stable(z_q))
      else $error("literal load wrong");
   or_lit_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q3 &&
      dec_q.kind == oie_pkg::OIE_K_OR_LIT
      |=> res_q == ($past(w_q) | $past(opnd_q))) else $error("or wrong");

   // destinations and flags of the file forms
   file_zero_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q4 &&
      dec_q.kind == oie_pkg::OIE_K_OR_FILE
      |=> z_q == ($past(res_q) == 8'h00))
      else $error("or file zero flag wrong");
   or_acc_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q4 &&
      dec_q.kind == oie_pkg::OIE_K_OR_FILE && !dec_q.to_file
      |=> w_q == $past(res_q) && !fw_q.we)
      else $error("or to accumulator wrong");
   inc_w_dest_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q4 &&
      dec_q.kind == oie_pkg::OIE_K_INC_SKIP && !dec_q.to_file
      |=> w_q == $past(res_q) && !fw_q.we)
      else $error("increment to accumulator wrong");

   // freeze and skip bookkeeping
   en_freeze_a: assert property (!clk_en
      |=> $stable(ph_q) && $stable(pc_q) && $stable(w_q) && $stable(z_q))
      else $error("state moved while disabled");
   skip_clear_a: assert property (clk_en && ph_q == oie_pkg::OIE_Q4 &&
      skip_q |=> !skip_q && pc_q == $past(pc_q) + 13'h0001)
      else $error("skip held too long");

   skip_c: cover property (skip_q && ph_q == oie_pkg::OIE_Q4);
   load_c: cover property (clk_en && ph_q == oie_pkg::OIE_Q4 &&
      dec_q.kind == oie_pkg::OIE_K_LOAD_LIT);
   or_file_c: cover property (fw_q.we);
   zero_c: cover property ($rose(z_q));
endmodule // oie_exec

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic [13:0] instr = 14'h0000;
   logic [12:0] pc;
   logic [6:0] file_raddr;
   logic [7:0] file_rdata;
   oie_pkg::oie_fwr_t file_wr;
   logic [7:0] w_acc;
   logic zero_flag;
   oie_pkg::oie_phase_t phase;
   logic skipping;
   logic [7:0] mem [128];
   logic [12:0] exp_pc = 13'h0000;
   int error_cnt = 0;
   int comparisons = 0;
   oie_pkg::oie_phase_t ph_seq [4] = '{oie_pkg::OIE_Q2, oie_pkg::OIE_Q3,
      oie_pkg::OIE_Q4, oie_pkg::OIE_Q1};

   always #10 clk = ~clk;

   // register file stand-in
   assign file_rdata = mem[file_raddr];
   always @(posedge clk) begin
      if (file_wr.we && clk_en) begin
         mem[file_wr.addr] <= file_wr.data;
      end
   end

   oie_exec u_oie_exec (.clk(clk), .reset(reset), .clk_en(clk_en),
      .instr(instr), .pc(pc), .file_raddr(file_raddr),
      .file_rdata(file_rdata), .file_wr(file_wr), .w_acc(w_acc),
      .zero_flag(zero_flag), .phase(phase), .skipping(skipping));

   ////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [15:0] seen,
                        input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up;
      if (error_cnt == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // one word, one full instruction cycle
   task automatic issue(input logic [13:0] word);
      instr = word;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         #1;
         check("phase", 16'(phase), 16'(ph_seq[i]));
      end
      exp_pc = exp_pc + 13'h0001;
      check("pc", 16'(pc), 16'(exp_pc));
   endtask

   task automatic t_reset;
      check("pc", 16'(pc), 16'h0000);
      check("w", 16'(w_acc), 16'h0000);
      check("fwr", 16'(file_wr), 16'h0000);
      check("skip", 16'(skipping), 16'h0000);
   endtask

   task automatic t_load;
      issue(14'h33A5);
      check("w", 16'(w_acc), 16'h00A5);
      check("z", 16'(zero_flag), 16'h0000);
      issue(14'h3000);
      check("w", 16'(w_acc), 16'h0000);
      check("z", 16'(zero_flag), 16'h0000);
      clk_en = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("pc", 16'(pc), 16'(exp_pc));
      check("phase", 16'(phase), 16'(oie_pkg::OIE_Q1));
      clk_en = 1'b1;
   endtask

   task automatic t_or_lit;
      issue(14'h3800);
      check("z", 16'(zero_flag), 16'h0001);
      issue(14'h309A);
      check("z", 16'(zero_flag), 16'h0001);
      issue(14'h3835);
      check("w", 16'(w_acc), 16'h00BF);
      check("z", 16'(zero_flag), 16'h0000);
   endtask

   task automatic t_or_file;
      mem[7'h13] = 8'h13;
      mem[7'h7F] = 8'h00;
      issue(14'h3091);
      issue(14'h0413);
      check("w", 16'(w_acc), 16'h0093);
      check("we", 16'(file_wr.we), 16'h0000);
      check("raddr", 16'(file_raddr), 16'h0013);
      issue(14'h3000);
      issue(14'h04FF);
      check("fwr", 16'(file_wr), {1'b1, 7'h7F, 8'h00});
      check("z", 16'(zero_flag), 16'h0001);
   endtask

   task automatic t_inc;
      mem[7'h10] = 8'h41;
      // 7F still has a write in flight from the last or-to-file
      mem[7'h2A] = 8'hFF;
      issue(14'h0F90);
      check("fwr", 16'(file_wr), {1'b1, 7'h10, 8'h42});
      check("w", 16'(w_acc), 16'h0000);
      check("z", 16'(zero_flag), 16'h0001);
      check("skip", 16'(skipping), 16'h0000);
      issue(14'h3811);
      check("w", 16'(w_acc), 16'h0011);
      issue(14'h0F2A);
      check("w", 16'(w_acc), 16'h0000);
      check("z", 16'(zero_flag), 16'h0000);
      check("skip", 16'(skipping), 16'h0001);
      issue(14'h3077);
      check("w", 16'(w_acc), 16'h0000);
      check("skip", 16'(skipping), 16'h0000);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      #1;
      t_reset();
      reset = 1'b0;
      t_load();
      t_or_lit();
      t_or_file();
      t_inc();
      wrap_up();
   end

   initial begin
      #100000;
      error_cnt++;
      wrap_up();
   end
endmodule // tb_top
